/* File: cfr_config_reg.sv */
// Configuration register with shared interrupt / auxiliary output pin logic
`timescale 1ns/1ps
`default_nettype none
module cfr_config_reg (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_sys_rst,
  // Internal register port from the serial front end
  input  wire cfr_pkg::cfr_req_s          i_reg_req,
  output var  logic [7:0]                 o_reg_rdata,
  output var  logic                       o_reg_rvalid,
  // Neighbouring register contents
  input  wire logic [3:0]                 i_master_intensity,
  input  wire logic [63:0]                i_port_intensity,
  input  wire logic [15:0]                i_port_is_input,
  // Pins
  input  wire logic [15:0]                i_port_pin,
  input  wire logic                       i_flash_phase_pin,
  output var  logic                       o_shared_irq_aux_pin_out,
  output var  logic                       o_shared_irq_aux_pin_oe_n,
  // Status towards the port and PWM logic
  output var  logic                       o_blink_phase,
  output var  logic [3:0]                 o_aux_output_intensity,
  output var  logic [63:0]                o_port_intensity_sel,
  output var  logic                       o_change_flag,
  output var  cfr_pkg::cfr_cfg_s          o_cfg
);
  import cfr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [CFR_SYNC_W-1:0] sync_w;
  logic [15:0]           port_sync;
  logic                  flash_sync;

  cfr_sync2 #(.W(CFR_SYNC_W)) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_flash_phase_pin, i_port_pin}),
    .o_sync    (sync_w)
  );

  assign port_sync  = sync_w[15:0];
  assign flash_sync = sync_w[CFR_SYNC_W-1];

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  wire cfg_hit  = (i_reg_req.addr == CFR_ADDR_CONFIG);
  wire cfg_wr   = i_reg_req.wr && cfg_hit;
  wire cfg_rd   = i_reg_req.rd && cfg_hit;
  wire in_lo_rd = i_reg_req.rd && (i_reg_req.addr == CFR_ADDR_INPUT_LO);
  wire in_hi_rd = i_reg_req.rd && (i_reg_req.addr == CFR_ADDR_INPUT_HI);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration bits D5..D0
  cfr_cfg_s cfg_r;
  cfr_cfg_s cfg_nxt;

  // Upper data bits are status only
  assign cfg_nxt = cfg_wr ? cfr_cfg_s'(i_reg_req.wdata[CFR_CFG_W-1:0]) : cfg_r;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg_r <= cfr_cfg_s'(CFR_CFG_RST);
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change detection
  // Snapshot is taken one cycle after reset release, since a reset load
  // may only use constants; the flag is held off until then.
  logic [15:0] snap_r;
  logic [15:0] snap_nxt;
  logic        init_r;
  logic        flag_r;
  logic        flag_nxt;
  logic [15:0] diff;

  assign snap_nxt[7:0]  = (init_r || cfg_wr || in_lo_rd) ? port_sync[7:0]  : snap_r[7:0];
  assign snap_nxt[15:8] = (init_r || cfg_wr || in_hi_rd) ? port_sync[15:8] : snap_r[15:8];

  // Flag tracks live mismatch, so it drops when inputs return
  assign diff     = (port_sync ^ snap_nxt) & i_port_is_input;
  assign flag_nxt = ~init_r && (|diff);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      snap_r <= 16'h0000;
      init_r <= 1'b1;
      flag_r <= 1'b0;
    end else begin
      snap_r <= snap_nxt;
      init_r <= 1'b0;
      flag_r <= flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink phase and shared pin
  wire phase_nxt  = cfg_nxt.flash_enable & (cfg_nxt.flash_flip ^ flash_sync);
  wire aux_level  = phase_nxt ? cfg_nxt.phase1_level_bit
                              : cfg_nxt.phase0_level_bit;
  wire drive_low  = cfg_nxt.irq_select ? flag_nxt : ~aux_level;

  ////////////////////////////////////////////////////////////////////////////
  // Intensity selection
  logic [63:0] int_sel;

  generate
    for (genvar p = 0; p < CFR_PORTS; p++) begin : g_int
      assign int_sel[p*CFR_INT_W +: CFR_INT_W] =
        cfg_nxt.shared_level ? i_master_intensity
                             : i_port_intensity[p*CFR_INT_W +: CFR_INT_W];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data: live status in the top two bits
  wire [7:0] cfg_rdata = {flag_r, flash_sync, cfg_r};

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rdata  <= cfg_rd ? cfg_rdata : 8'h00;
      o_reg_rvalid <= cfg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  // Pin is open drain: level is always low, enable decides low or released
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_shared_irq_aux_pin_out  <= 1'b0;
      o_shared_irq_aux_pin_oe_n <= 1'b1;
      o_blink_phase             <= 1'b0;
      o_aux_output_intensity    <= 4'h0;
      o_port_intensity_sel      <= 64'h0000_0000_0000_0000;
      o_change_flag             <= 1'b0;
      o_cfg                     <= cfr_cfg_s'(CFR_CFG_RST);
    end else begin
      o_shared_irq_aux_pin_out  <= 1'b0;
      o_shared_irq_aux_pin_oe_n <= ~drive_low;
      o_blink_phase             <= phase_nxt;
      o_aux_output_intensity    <= i_master_intensity;
      o_port_intensity_sel      <= int_sel;
      o_change_flag             <= flag_nxt;
      o_cfg                     <= cfg_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: cfr_config_reg_monitor.sv */
// Port-level checker for the configuration register block
`timescale 1ns/1ps
`default_nettype none
module cfr_config_reg_monitor (
  input wire logic              i_clk,
  input wire logic              i_sys_rst,
  input wire cfr_pkg::cfr_req_s i_reg_req,
  input wire logic [7:0]        o_reg_rdata,
  input wire logic              o_reg_rvalid,
  input wire logic [3:0]        i_master_intensity,
  input wire logic [63:0]       i_port_intensity,
  input wire logic [15:0]       i_port_is_input,
  input wire logic              o_shared_irq_aux_pin_oe_n,
  input wire logic              o_blink_phase,
  input wire logic [3:0]        o_aux_output_intensity,
  input wire logic [63:0]       o_port_intensity_sel,
  input wire logic              o_change_flag,
  input wire cfr_pkg::cfr_cfg_s o_cfg
);
  import cfr_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic rd_c = i_reg_req.rd && i_reg_req.addr == CFR_ADDR_CONFIG;
  wire logic wr_c = i_reg_req.wr && i_reg_req.addr == CFR_ADDR_CONFIG;
  wire logic oe_n = o_shared_irq_aux_pin_oe_n;
  a_read_answer: assert property (rd_c |=> o_reg_rvalid)
    else $error("config read not answered");
  a_read_bits: assert property (o_reg_rvalid |-> o_reg_rdata[5:0] == $past(o_cfg))
    else $error("read data differs from config");
  a_write_cfg: assert property (wr_c |=> o_cfg == $past(i_reg_req.wdata[5:0]))
    else $error("written config not held");
  a_irq_pin: assert property (o_cfg.irq_select && $stable(o_cfg) && $stable(o_change_flag)
    |-> oe_n == !o_change_flag) else $error("irq pin wrong");
  a_aux_static: assert property (!o_cfg.irq_select && !o_cfg.flash_enable && $stable(o_cfg)
    |-> oe_n == o_cfg.phase0_level_bit) else $error("aux level wrong");
  a_aux_blink: assert property (!o_cfg.irq_select && $stable(o_cfg) && $stable(o_blink_phase)
    |-> oe_n == (o_blink_phase ? o_cfg.phase1_level_bit : o_cfg.phase0_level_bit))
    else $error("aux blink level wrong");
  a_phase_off: assert property (!o_cfg.flash_enable && $stable(o_cfg) |-> !o_blink_phase)
    else $error("phase moved with blink off");
  a_aux_intensity: assert property (!$past(i_sys_rst)
    |-> o_aux_output_intensity == $past(i_master_intensity)) else $error("aux intensity");
  a_global_int: assert property (o_cfg.shared_level && $stable(o_cfg) && !$past(i_sys_rst)
    && !i_port_is_input[0] |-> o_port_intensity_sel[3:0] == $past(i_master_intensity))
    else $error("global intensity not applied");
  a_port_int: assert property (!o_cfg.shared_level && $stable(o_cfg) && !$past(i_sys_rst)
    && !i_port_is_input[0] |-> o_port_intensity_sel[3:0] == $past(i_port_intensity[3:0]))
    else $error("port intensity not applied");
endmodule
bind cfr_config_reg cfr_config_reg_monitor u_mon (.*);
`default_nettype wire

/* File: cfr_host.sv */
// Register master model standing for the serial host side
`timescale 1ns/1ps
`default_nettype none
module cfr_host (
  input  wire logic              i_clk,
  output var  cfr_pkg::cfr_req_s o_req
);
  import cfr_pkg::*;
  initial o_req = '0;
  // Idle fields are inverted so stale values are never trusted
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_clk);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

/* File: cfr_pkg.sv */
// Constants and carrier types for the configuration register block
package cfr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] CFR_ADDR_INPUT_LO = 8'h00;
  localparam logic [7:0] CFR_ADDR_INPUT_HI = 8'h01;
  localparam logic [7:0] CFR_ADDR_MASTER   = 8'h0E;
  localparam logic [7:0] CFR_ADDR_CONFIG   = 8'h0F;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of device_configuration
  localparam int CFR_BIT_CHANGE_FLAG  = 7;
  localparam int CFR_BIT_FLASH_STATUS = 6;
  localparam int CFR_BIT_PHASE1_LEVEL = 5;
  localparam int CFR_BIT_PHASE0_LEVEL = 4;
  localparam int CFR_BIT_IRQ_SELECT   = 3;
  localparam int CFR_BIT_SHARED_LEVEL = 2;
  localparam int CFR_BIT_FLASH_FLIP   = 1;
  localparam int CFR_BIT_FLASH_ENABLE = 0;

  // Writable part, D5..D0
  localparam int         CFR_CFG_W   = 6;
  localparam logic [5:0] CFR_CFG_RST = 6'h0C;

  localparam int CFR_PORTS  = 16;
  localparam int CFR_INT_W  = 4;
  localparam int CFR_SYNC_W = CFR_PORTS + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic phase1_level_bit;
    logic phase0_level_bit;
    logic irq_select;
    logic shared_level;
    logic flash_flip;
    logic flash_enable;
  } cfr_cfg_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfr_req_s;

endpackage

/* File: cfr_sync2.sv */
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module cfr_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  // Data
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
  import cfr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        flash = 1'b0;
  logic [3:0]  mi = 4'h0;
  logic [63:0] pint = 64'h0;
  logic [15:0] pins = 16'h0000;
  logic [31:0] seed = 32'h0000_8A38;
  logic [7:0]  rdata, ex;
  logic        rvalid, oe_n, flag;
  logic        pin_out, phase;
  logic [3:0]  mi_d, aux_int;
  logic [63:0] pint_d, int_sel;
  logic [5:0]  v;
  cfr_req_s    req;
  cfr_cfg_s    cfg;
  int          err_count = 0;
  int          checks_done = 0;
  logic [7:0]  q[$];
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    seed <= xs(seed);
    mi <= seed[3:0];
    pint <= {seed, ~seed};
    // Copies of what the design sampled at this edge
    mi_d <= mi;
    pint_d <= pint;
  end
  cfr_host u_host (.i_clk(clk), .o_req(req));
  cfr_config_reg dut (
    .i_clk(clk), .i_sys_rst(rst), .i_reg_req(req), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_master_intensity(mi), .i_port_intensity(pint),
    .i_port_is_input(16'hFFFE), .i_port_pin(pins), .i_flash_phase_pin(flash),
    .o_shared_irq_aux_pin_out(pin_out), .o_shared_irq_aux_pin_oe_n(oe_n),
    .o_blink_phase(phase), .o_aux_output_intensity(aux_int),
    .o_port_intensity_sel(int_sel), .o_change_flag(flag), .o_cfg(cfg));
  // Every answer must match the oldest expected read
  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      ex = (q.size() == 0) ? 8'hxx : q.pop_front();
      `CHK("rdata", ex, rdata)
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd_cfg(input logic [7:0] e);
    q.push_back(e);
    u_host.xfer(1'b0, CFR_ADDR_CONFIG, 8'h00);
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("cfg reset", 6'h0C, cfg)
    rd_cfg(8'h0C);
    u_host.xfer(1'b1, CFR_ADDR_CONFIG, 8'hFF);
    rd_cfg(8'h3F);
    u_host.xfer(1'b0, 8'h05, 8'h00);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      v = seed[5:0] & 6'h37;
      flash <= seed[8];
      idle(4);
      u_host.xfer(1'b1, CFR_ADDR_CONFIG, {seed[7:6], v});
      idle(1);
      @(negedge clk);
      `CHK("aux pin", (v[0] & (v[1] ^ flash)) ? v[5] : v[4], oe_n)
      `CHK("blink phase", v[0] & (v[1] ^ flash), phase)
      `CHK("aux intensity", mi_d, aux_int)
      `CHK("port0 intensity", v[2] ? mi_d : pint_d[3:0], int_sel[3:0])
      `CHK("pin level", 1'b0, pin_out)
      rd_cfg({1'b0, flash, v});
    end
    u_host.xfer(1'b1, CFR_ADDR_CONFIG, 8'h08);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      pins <= pins ^ 16'h0010;
      idle(5);
      @(negedge clk);
      `CHK("flag and pin", 2'b10, {flag, oe_n})
      `CHK("irq pin level", 1'b0, pin_out)
      rd_cfg({1'b1, flash, 6'h08});
      case (k)
        0: pins <= pins ^ 16'h0010;
        1: u_host.xfer(1'b0, CFR_ADDR_INPUT_LO, 8'h00);
        default: u_host.xfer(1'b1, CFR_ADDR_CONFIG, 8'h08);
      endcase
      idle(5);
      @(negedge clk);
      `CHK("flag cleared", 2'b01, {flag, oe_n})
    end
    idle(3);
    stop_test();
  end
endmodule
`default_nettype wire
